// ==== rtl/hrsm_defs.svh ====
// Constants of the hub repeater state machine: sizes, state codes and timing counts
`ifndef HRSM_DEFS_SVH
`define HRSM_DEFS_SVH

// Structure sizes
`define HRSM_PORTS 4
`define HRSM_DATA_W 8
`define HRSM_FIFO_DEPTH 8

// State codes, Gray ordered along wait-up, repeat-down, wait-any, repeat-up
`define HRSM_ST_AWAIT_UP 2'h0
`define HRSM_ST_REP_DOWN 2'h1
`define HRSM_ST_AWAIT_ANY 2'h3
`define HRSM_ST_REP_UP 2'h2

// Hub clock period and bit times, in picoseconds
`define HRSM_CLK_PERIOD_PS 20000
`define HRSM_FS_BIT_PS 83334
`define HRSM_LS_BIT_PS 666667

// Least times round up to whole cycles
`define HRSM_FS_BIT_CYC ((`HRSM_FS_BIT_PS + `HRSM_CLK_PERIOD_PS - 1) / `HRSM_CLK_PERIOD_PS)
`define HRSM_LS_BIT_CYC ((`HRSM_LS_BIT_PS + `HRSM_CLK_PERIOD_PS - 1) / `HRSM_CLK_PERIOD_PS)
`define HRSM_CNT_W 6

`endif

// ==== rtl/hrsm_fifo.sv ====
// Repeat-path FIFO with valid/ready on both sides
`timescale 1ns/1ps
module hrsm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Drain side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    // Status
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic doWrite;
    logic doRead;

    // Handshakes; full and empty follow the occupancy count
    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign empty = (count == '0);
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    assign outData = mem[rdPtr];

    // Storage has no reset; only words under the count are ever read
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
            end
            if (doRead) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
            end
        end
    end

    // Occupancy
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
        end else if (doWrite && !doRead) begin
            count <= count + (AW+1)'(1);
        end else if (doRead && !doWrite) begin
            count <= count - (AW+1)'(1);
        end
    end
endmodule

// ==== rtl/hrsm_pkg.sv ====
// Types shared by the hub repeater state machine and its bench
package hrsm_pkg;
`include "hrsm_defs.svh"

    // Repeater connectivity states
    typedef enum logic [1:0] {
        ST_AWAIT_UPSTREAM_START = `HRSM_ST_AWAIT_UP,
        ST_REPEAT_DOWNSTREAM_DIR = `HRSM_ST_REP_DOWN,
        ST_AWAIT_ANY_START = `HRSM_ST_AWAIT_ANY,
        ST_REPEAT_UPSTREAM_DIR = `HRSM_ST_REP_UP
    } hrsm_state_e;

    typedef logic [`HRSM_PORTS-1:0] hrsm_port_t;

    // One repeated data word and its packet-end mark
    typedef struct packed {
        logic [`HRSM_DATA_W-1:0] data;
        logic last;
    } hrsm_word_s;

    // Upstream receiver state levels
    typedef struct packed {
        logic busReset;
        logic suspend;
        logic resume;
    } hrsm_rx_state_s;

    // Frame timer indications
    typedef struct packed {
        logic firstFrameEndPoint;
        logic secondFrameEndPoint;
        logic locked;
    } hrsm_frame_s;
endpackage

// ==== rtl/hrsm_repeater.sv ====
// Hub repeater state machine: connectivity direction, packet ends and repeat-path FIFO
//
// Behaviour
// - Receiver bus reset sends the repeater to await upstream start from any state.
// - Awaiting any start, frame timer at or past first point goes to await upstream.
// - Repeating upstream, the second frame end point goes to await upstream start.
// - Repeating downstream, upstream packet end while unlocked goes to await upstream.
// - Awaiting upstream start: no connectivity, downstream ignored, only upstream start.
// - Upstream packet start in either wait state enters downstream repeating.
// - Receiver resume from either wait or upstream repeating enters downstream repeating.
// - Downstream repeating connects all enabled ports; entry puts them in transmit.
// - Repeating upstream, downstream packet end returns to await any start.
// - Repeating downstream, upstream packet end while locked returns to await any start.
// - Receiver suspend from await upstream or downstream repeating goes to await any.
// - Awaiting any start: no connectivity, watch upstream and every enabled port.
// - Awaiting any start, enabled downstream port start enters upstream repeating.
// - Upstream repeating drives source port upstream; entry activates upstream transmitter.
// - Still upstream repeating at second point disables source port as babbling.
// - High-speed packet end is buffer drained, resume-end exit or receiver interval end.
// - Downstream packet end is raised when the transmitter enters idle drive.
// - Each frame end point indication holds from its point to frame end.
// - Packet start is the Idle-to-K edge; at high speed, after selector validation.
// - Upstream repeating holds past the first point until packet end or second point.
// - High-speed packet-end transitions wait until the last buffered bit is repeated.
// - Full/low-speed packet-end transitions wait for J driven one bit time.
`timescale 1ns/1ps
`include "hrsm_defs.svh"
module hrsm_repeater
    import hrsm_pkg::*;
(
    // Hub clock and synchronous reset
    input wire logic clk,
    input wire logic rst_n,
    // Upstream receiver state and frame timer, hub clock domain
    input wire hrsm_rx_state_s rxState,
    input wire hrsm_frame_s frame,
    // Link speed
    input wire logic hsMode,
    input wire logic lowSpeed,
    // Packet start events
    input wire logic upIdleToK,
    input wire logic upHsPacketStart,
    input wire hrsm_port_t dsIdleToK,
    input wire hrsm_port_t dsHsPacketStart,
    input wire hrsm_port_t portEnabled,
    // Packet end sources
    input wire logic bufferDrained,
    input wire hrsm_port_t sendResumeEnd,
    input wire logic receiverIntervalEnd,
    input wire logic upFsIdleEdge,
    input wire logic txDriveIdle,
    // Repeated data in from the connected source
    input wire hrsm_word_s srcWord,
    input wire logic srcValid,
    output logic srcReady,
    // Repeated data out to the transmitter
    output hrsm_word_s sinkWord,
    output logic sinkValid,
    input wire logic sinkReady,
    // Connectivity and port control
    output hrsm_state_e repState,
    output hrsm_port_t dsConnect,
    output logic usConnect,
    output hrsm_port_t sourcePort,
    output hrsm_port_t dsTransmitStart,
    output logic usTxActivate,
    output hrsm_port_t babbleDisable
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Lowest-numbered port of a mask, one-hot; ties between colliding starts go low
    function automatic hrsm_port_t pick_lowest(input hrsm_port_t mask);
        hrsm_port_t res;
        res = '0;
        for (int i = `HRSM_PORTS - 1; i >= 0; i--) begin
            if (mask[i]) begin
                res = '0;
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction

    // Bit time in hub clocks for the current signalling rate
    function automatic logic [`HRSM_CNT_W-1:0] bit_cycles(input logic slow);
        return slow ? `HRSM_CNT_W'(`HRSM_LS_BIT_CYC) : `HRSM_CNT_W'(`HRSM_FS_BIT_CYC);
    endfunction

    hrsm_state_e state;
    hrsm_state_e next_state;
    logic startUp;
    hrsm_port_t startDown;
    logic hsPacketEnd;
    logic driveIdleSeen;
    logic driveIdleEntry;
    logic rawEnd;
    logic endPending;
    logic [`HRSM_CNT_W-1:0] endCount;
    logic endDone;
    logic fifoEmpty;
    logic connected;
    logic fifoInValid;
    logic fifoInReady;
    logic [$bits(hrsm_word_s)-1:0] fifoOut;

    ////////////////////////////////////////////////////////////////////////////////
    // Event decoding

    // Start events: Idle-to-K edge, or the selector's validated start at high speed
    assign startUp = hsMode ? upHsPacketStart : upIdleToK;
    assign startDown = (hsMode ? dsHsPacketStart : dsIdleToK) & portEnabled;

    // High-speed end is any of the three sources
    assign hsPacketEnd = bufferDrained || (|sendResumeEnd) || receiverIntervalEnd;

    // Downstream end fires on entry of the transmitter into idle drive
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            driveIdleSeen <= 1'b0;
        end else begin
            driveIdleSeen <= txDriveIdle;
        end
    end
    assign driveIdleEntry = txDriveIdle && !driveIdleSeen;

    // Raw end matters only in the state that waits for it from that direction
    always_comb begin
        rawEnd = 1'b0;
        if (state == ST_REPEAT_DOWNSTREAM_DIR) begin
            rawEnd = hsMode ? hsPacketEnd : upFsIdleEdge;
        end else if (state == ST_REPEAT_UPSTREAM_DIR) begin
            rawEnd = hsMode ? hsPacketEnd : driveIdleEntry;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Packet-end qualification

    // A raw end is held pending; leaving the repeating state drops it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            endPending <= 1'b0;
        end else if (next_state != state) begin
            endPending <= 1'b0;
        end else if (rawEnd) begin
            endPending <= 1'b1;
        end
    end

    // Counts J for one bit time at full/low speed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            endCount <= '0;
        end else if (rawEnd && !endPending) begin
            endCount <= bit_cycles(lowSpeed);
        end else if (endPending && endCount != '0) begin
            endCount <= endCount - `HRSM_CNT_W'(1);
        end
    end

    // High speed waits for the FIFO to hold no unrepeated word
    assign endDone = endPending && (hsMode ? (fifoEmpty && !fifoInValid)
                                           : (endCount == '0));

    ////////////////////////////////////////////////////////////////////////////////
    // State machine

    always_comb begin
        next_state = state;
        case (state)
            ST_AWAIT_UPSTREAM_START: begin
                // Downstream starts are not looked at here
                if (rxState.resume || startUp) begin
                    next_state = ST_REPEAT_DOWNSTREAM_DIR;
                end else if (rxState.suspend) begin
                    next_state = ST_AWAIT_ANY_START;
                end
            end
            ST_REPEAT_DOWNSTREAM_DIR: begin
                if (rxState.suspend) begin
                    next_state = ST_AWAIT_ANY_START;
                end else if (endDone && frame.locked) begin
                    next_state = ST_AWAIT_ANY_START;
                end else if (endDone) begin
                    next_state = ST_AWAIT_UPSTREAM_START;
                end
            end
            ST_AWAIT_ANY_START: begin
                // An upstream start at the first point is still taken, so an SOF is never missed
                if (rxState.resume || startUp) begin
                    next_state = ST_REPEAT_DOWNSTREAM_DIR;
                end else if (frame.firstFrameEndPoint) begin
                    next_state = ST_AWAIT_UPSTREAM_START;
                end else if (startDown != '0) begin
                    next_state = ST_REPEAT_UPSTREAM_DIR;
                end
            end
            ST_REPEAT_UPSTREAM_DIR: begin
                // The first point alone does not end this state
                if (frame.secondFrameEndPoint) begin
                    next_state = ST_AWAIT_UPSTREAM_START;
                end else if (rxState.resume) begin
                    next_state = ST_REPEAT_DOWNSTREAM_DIR;
                end else if (endDone) begin
                    next_state = ST_AWAIT_ANY_START;
                end
            end
            default: begin
                next_state = ST_AWAIT_UPSTREAM_START;
            end
        endcase
        if (rxState.busReset) begin
            next_state = ST_AWAIT_UPSTREAM_START;
        end
    end

    // State register; reset lands in the upstream wait, like a bus reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_AWAIT_UPSTREAM_START;
        end else begin
            state <= next_state;
        end
    end
    assign repState = state;

    ////////////////////////////////////////////////////////////////////////////////
    // Connectivity outputs

    // Source port is caught on entry to upstream repeating
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sourcePort <= '0;
        end else if (next_state == ST_REPEAT_UPSTREAM_DIR && state != ST_REPEAT_UPSTREAM_DIR) begin
            sourcePort <= pick_lowest(startDown);
        end else if (next_state != ST_REPEAT_UPSTREAM_DIR) begin
            sourcePort <= '0;
        end
    end

    // Connectivity levels follow the next state so they line up with it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dsConnect <= '0;
            usConnect <= 1'b0;
        end else begin
            dsConnect <= (next_state == ST_REPEAT_DOWNSTREAM_DIR) ? portEnabled : '0;
            usConnect <= (next_state == ST_REPEAT_UPSTREAM_DIR);
        end
    end

    // Entry pulses: enabled ports to transmit, upstream transmitter to active
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dsTransmitStart <= '0;
            usTxActivate <= 1'b0;
        end else begin
            dsTransmitStart <= (next_state == ST_REPEAT_DOWNSTREAM_DIR && state != ST_REPEAT_DOWNSTREAM_DIR)
                               ? portEnabled : '0;
            usTxActivate <= (next_state == ST_REPEAT_UPSTREAM_DIR && state != ST_REPEAT_UPSTREAM_DIR);
        end
    end

    // Babble: still repeating upstream at the second point, bus reset excepted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            babbleDisable <= '0;
        end else begin
            babbleDisable <= (state == ST_REPEAT_UPSTREAM_DIR && frame.secondFrameEndPoint && !rxState.busReset)
                             ? sourcePort : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Repeat path

    // Words enter the FIFO only while connected; otherwise the source is held off, and buffered words still drain
    assign connected = (state == ST_REPEAT_DOWNSTREAM_DIR) || (state == ST_REPEAT_UPSTREAM_DIR);
    assign fifoInValid = srcValid && connected;
    assign srcReady = fifoInReady && connected;

    hrsm_fifo #(
        .WIDTH($bits(hrsm_word_s)),
        .DEPTH(`HRSM_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .inData(srcWord),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .outData(fifoOut),
        .outValid(sinkValid),
        .outReady(sinkReady),
        .empty(fifoEmpty)
    );
    assign sinkWord = hrsm_word_s'(fifoOut);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_reset_wins;
        rxState.busReset |=> state == ST_AWAIT_UPSTREAM_START;
    endproperty
    a_reset_wins: assert property (p_reset_wins) else $error("bus reset did not force upstream wait");

    property p_first_point;
        state == ST_AWAIT_ANY_START && frame.firstFrameEndPoint && !rxState.busReset
            && !rxState.resume && !startUp |=> state == ST_AWAIT_UPSTREAM_START;
    endproperty
    a_first_point: assert property (p_first_point) else $error("first point ignored in any-start wait");

    property p_second_point;
        state == ST_REPEAT_UPSTREAM_DIR && frame.secondFrameEndPoint && !rxState.busReset
            |=> state == ST_AWAIT_UPSTREAM_START && babbleDisable == $past(sourcePort) && babbleDisable != '0;
    endproperty
    a_second_point: assert property (p_second_point) else $error("second point missed or no babble");

    property p_babble_only_upstream;
        babbleDisable != '0 |-> $past(state) == ST_REPEAT_UPSTREAM_DIR;
    endproperty
    a_babble_only_upstream: assert property (p_babble_only_upstream) else $error("babble outside upstream repeat");

    property p_down_end_lock;
        state == ST_REPEAT_DOWNSTREAM_DIR && endDone && !rxState.busReset && !rxState.suspend
            |=> state == ($past(frame.locked) ? ST_AWAIT_ANY_START : ST_AWAIT_UPSTREAM_START);
    endproperty
    a_down_end_lock: assert property (p_down_end_lock) else $error("wrong exit on upstream packet end");

    property p_ignore_downstream;
        state == ST_AWAIT_UPSTREAM_START && !startUp && !rxState.resume && !rxState.suspend
            |=> state == ST_AWAIT_UPSTREAM_START && dsConnect == '0 && !usConnect;
    endproperty
    a_ignore_downstream: assert property (p_ignore_downstream) else $error("left upstream wait without cause");

    property p_enter_down;
        state != ST_REPEAT_DOWNSTREAM_DIR ##1 state == ST_REPEAT_DOWNSTREAM_DIR
            |-> dsTransmitStart == $past(portEnabled) && dsConnect == $past(portEnabled);
    endproperty
    a_enter_down: assert property (p_enter_down) else $error("enabled ports not started on entry");

    property p_enter_up;
        state != ST_REPEAT_UPSTREAM_DIR ##1 state == ST_REPEAT_UPSTREAM_DIR
            |-> usTxActivate && usConnect && $onehot(sourcePort);
    endproperty
    a_enter_up: assert property (p_enter_up) else $error("upstream entry without activation");

    property p_hs_drain;
        hsMode && endPending && !fifoEmpty && rxState == '0 && !frame.secondFrameEndPoint
            |=> state == $past(state);
    endproperty
    a_hs_drain: assert property (p_hs_drain) else $error("high-speed end taken before drain");

    property p_fs_bit_time;
        !hsMode && rawEnd && !endPending && next_state == state |=> !endDone [*4];
    endproperty
    a_fs_bit_time: assert property (p_fs_bit_time) else $error("packet end taken before one bit of J");

    c_down_packet: cover property (state == ST_REPEAT_DOWNSTREAM_DIR ##[1:200] state == ST_AWAIT_ANY_START);
    c_up_packet: cover property (state == ST_REPEAT_UPSTREAM_DIR ##[1:200] state == ST_AWAIT_ANY_START);
    c_babble: cover property (babbleDisable != '0);
    c_fifo_full: cover property (!fifoInReady && connected);
endmodule

// ==== verif/hrsm_far_side.sv ====
// Far-side sink model: upstream transmitter taking repeated words
`timescale 1ns/1ps
module hrsm_far_side
    import hrsm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Stall command from the bench
    input wire logic stall,
    // Repeated words
    input wire hrsm_word_s sinkWord,
    input wire logic sinkValid,
    output logic sinkReady,
    // Words taken, one cycle late
    output hrsm_word_s gotWord,
    output logic gotValid
);
    // Random gaps model a slow line; ready moves only after an edge
    always_ff @(posedge clk) begin
        sinkReady <= rst_n && !stall && ($urandom_range(3) != 0);
    end
    // Record each word at the edge that takes it
    always_ff @(posedge clk) begin
        gotValid <= rst_n && sinkValid && sinkReady;
        gotWord <= sinkWord;
    end
endmodule

// ==== verif/tb.sv ====
// Bench for the hub repeater state machine against a cycle model
`timescale 1ns/1ps
`include "hrsm_defs.svh"
module tb
    import hrsm_pkg::*;
;
    localparam hrsm_state_e AU = ST_AWAIT_UPSTREAM_START;
    localparam hrsm_state_e RD = ST_REPEAT_DOWNSTREAM_DIR;
    localparam hrsm_state_e AA = ST_AWAIT_ANY_START;
    localparam hrsm_state_e RU = ST_REPEAT_UPSTREAM_DIR;
    logic clk = 0, rst_n = 0, hsMode = 0, lowSpeed = 0, upIdleToK = 0, upHsPacketStart = 0;
    logic bufferDrained = 0, receiverIntervalEnd = 0, upFsIdleEdge = 0, txDriveIdle = 0;
    logic srcValid = 0, stall = 0, srcReady, sinkValid, sinkReady, usConnect, usTxActivate, gotValid;
    logic eUs, eAct, pend, prevTx, up, raw, fire, acc;
    hrsm_rx_state_s rxState = '0;
    hrsm_frame_s frame = '0;
    hrsm_port_t dsIdleToK = '0, dsHsPacketStart = '0, portEnabled = 4'h6, sendResumeEnd = '0;
    hrsm_port_t dsConnect, sourcePort, dsTransmitStart, babbleDisable, eDs, eSrc, eTx, eBab, ds;
    hrsm_word_s srcWord = '0, sinkWord, gotWord;
    hrsm_word_s q[$];
    hrsm_state_e repState, eSt, nSt;
    int fail_count = 0, num_checks = 0, cnt, fcnt, n;

    always #10 clk = ~clk;

    hrsm_repeater i_hrsm_repeater (.clk, .rst_n, .rxState, .frame, .hsMode, .lowSpeed, .upIdleToK,
        .upHsPacketStart, .dsIdleToK, .dsHsPacketStart, .portEnabled, .bufferDrained, .sendResumeEnd,
        .receiverIntervalEnd, .upFsIdleEdge, .txDriveIdle, .srcWord, .srcValid, .srcReady, .sinkWord,
        .sinkValid, .sinkReady, .repState, .dsConnect, .usConnect, .sourcePort, .dsTransmitStart,
        .usTxActivate, .babbleDisable);
    hrsm_far_side i_hrsm_far_side (.clk, .rst_n, .stall, .sinkWord, .sinkValid, .sinkReady, .gotWord, .gotValid);

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle model, evaluated on the edge the design samples; inputs are stable here
    always @(posedge clk) begin
        if (!rst_n) begin
            eSt = AU;
            {eDs, eSrc, eTx, eBab, eUs, eAct, pend, cnt, fcnt} = '0;
            q.delete();
        end else begin
            ds = (hsMode ? dsHsPacketStart : dsIdleToK) & portEnabled;
            up = hsMode ? upHsPacketStart : upIdleToK;
            raw = hsMode ? (bufferDrained | (|sendResumeEnd) | receiverIntervalEnd)
                : (eSt == RD ? upFsIdleEdge : txDriveIdle && !prevTx);
            // High speed waits for an empty path, full/low speed for the bit time
            fire = pend && (hsMode ? (fcnt == 0 && !srcValid) : cnt == 0);
            nSt = eSt;
            eBab = '0;
            if (rxState.busReset) nSt = AU;
            else if (eSt == RU) begin
                if (frame.secondFrameEndPoint) begin
                    nSt = AU;
                    eBab = eSrc;
                end else if (rxState.resume) nSt = RD;
                else if (fire) nSt = AA;
            end else if (eSt == RD) begin
                if (rxState.suspend) nSt = AA;
                else if (fire) nSt = frame.locked ? AA : AU;
            end else if (rxState.resume || up) nSt = RD;
            else if (eSt == AU) begin
                if (rxState.suspend) nSt = AA;
            end else if (frame.firstFrameEndPoint) nSt = AU;
            else if (ds != 0) nSt = RU;
            // Repeating codes have odd parity; an end seen with a state change is lost
            if (nSt != eSt) pend = 0;
            else if (raw && ^eSt) begin
                pend = 1;
                cnt = lowSpeed ? `HRSM_LS_BIT_CYC : `HRSM_FS_BIT_CYC;
            end else if (pend && cnt != 0) cnt--;
            eTx = (nSt == RD && eSt != RD) ? portEnabled : '0;
            eAct = nSt == RU && eSt != RU;
            eDs = nSt == RD ? portEnabled : '0;
            eUs = nSt == RU;
            if (nSt != RU) eSrc = '0;
            else if (eSt != RU) eSrc = ds & (~ds + 1'b1);
            if (srcValid && srcReady) q.push_back(srcWord);
            fcnt = fcnt + (srcValid && srcReady) - (sinkValid && sinkReady);
            eSt = nSt;
        end
        prevTx = txDriveIdle;
    end

    task automatic check_val(input logic [3:0] got, input logic [3:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic check_word(input hrsm_word_s got);
        hrsm_word_s exp;
        num_checks++;
        exp = q.size() != 0 ? q.pop_front() : ~got;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    // Compare at every falling edge, after the rising edge has settled
    always @(negedge clk) begin
        check_val({2'b00, repState}, {2'b00, eSt}, "state");
        check_val(dsConnect, eDs, "dsConnect");
        check_val({3'b000, usConnect}, {3'b000, eUs}, "usConnect");
        check_val(sourcePort, eSrc, "sourcePort");
        check_val(dsTransmitStart, eTx, "dsTransmitStart");
        check_val({3'b000, usTxActivate}, {3'b000, eAct}, "usTxActivate");
        check_val(babbleDisable, eBab, "babbleDisable");
        check_val({3'b000, sinkValid}, {3'b000, fcnt != 0}, "sinkValid");
        if (gotValid === 1'b1) check_word(gotWord);
    end

    task automatic final_report;
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One-cycle events: starts, receiver state and packet-end sources
    task automatic ev(input hrsm_port_t d, input logic u, input logic [2:0] rx, input logic [2:0] e, input int hold);
        dsIdleToK = hsMode ? '0 : d;
        dsHsPacketStart = hsMode ? d : '0;
        upIdleToK = !hsMode && u;
        upHsPacketStart = hsMode && u;
        rxState = rx;
        {receiverIntervalEnd, bufferDrained, upFsIdleEdge} = e;
        @(negedge clk);
        {dsIdleToK, dsHsPacketStart, upIdleToK, upHsPacketStart, rxState} = '0;
        {receiverIntervalEnd, bufferDrained, upFsIdleEdge} = '0;
        repeat (hold) @(negedge clk);
    endtask

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(30048));
        repeat (2) @(negedge clk);
        rst_n = 1;
        ev(4'h2, 0, 3'b000, 3'b000, 2);
        ev(4'h0, 0, 3'b010, 3'b000, 2);
        ev(4'hE, 0, 3'b000, 3'b000, 2);
        txDriveIdle = 1;
        repeat (10) @(negedge clk);
        txDriveIdle = 0;
        ev(4'h0, 1, 3'b000, 3'b000, 1);
        // Fill the path against a stalled sink until it refuses, then drain with the stall released and only the sink's random gaps
        stall = 1;
        srcValid = 1;
        srcWord = 9'($urandom_range(511));
        n = 0;
        repeat (12) begin
            acc = srcReady;
            @(negedge clk);
            if (acc) begin
                n++;
                srcWord = 9'($urandom_range(511));
            end
        end
        srcValid = 0;
        check_val(4'(n), 4'h8, "fill count");
        stall = 0;
        repeat (40) @(negedge clk);
        frame.locked = 1;
        lowSpeed = 1;
        ev(4'h0, 0, 3'b000, 3'b001, 40);
        lowSpeed = 0;
        frame.firstFrameEndPoint = 1;
        repeat (2) @(negedge clk);
        ev(4'h0, 1, 3'b000, 3'b000, 1);
        frame = '0;
        ev(4'h0, 0, 3'b000, 3'b001, 8);
        ev(4'h0, 0, 3'b010, 3'b000, 1);
        ev(4'h4, 0, 3'b000, 3'b000, 1);
        frame.firstFrameEndPoint = 1;
        repeat (3) @(negedge clk);
        frame.secondFrameEndPoint = 1;
        repeat (2) @(negedge clk);
        frame = '0;
        ev(4'h0, 0, 3'b001, 3'b000, 1);
        ev(4'h0, 0, 3'b010, 3'b000, 1);
        ev(4'h2, 0, 3'b000, 3'b000, 1);
        ev(4'h0, 0, 3'b001, 3'b000, 1);
        ev(4'h0, 1, 3'b100, 3'b000, 1);
        // High-speed starts and the packet-end sources
        hsMode = 1;
        frame.locked = 1;
        ev(4'h0, 0, 3'b010, 3'b000, 1);
        ev(4'h4, 0, 3'b000, 3'b000, 1);
        stall = 1;
        srcValid = 1;
        repeat (2) @(negedge clk);
        srcValid = 0;
        ev(4'h0, 0, 3'b000, 3'b100, 4);
        stall = 0;
        repeat (12) @(negedge clk);
        ev(4'h0, 1, 3'b000, 3'b000, 1);
        ev(4'h0, 0, 3'b000, 3'b010, 4);
        ev(4'h2, 0, 3'b000, 3'b000, 1);
        sendResumeEnd = 4'h2;
        @(negedge clk);
        sendResumeEnd = '0;
        @(negedge clk);
        hsMode = 0;
        ev(4'h2, 0, 3'b100, 3'b000, 1);
        ev(4'h0, 1, 3'b000, 3'b000, 1);
        rst_n = 0;
        @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        final_report;
    end
endmodule
